// File: bench/readback_regs_bench.sv
// Purpose: Self-checking bench for the readback and resolution register
// Assumes: Serial host model drives the link pins
// Notes:   Expected words are built from field positions, not from outputs
`timescale 1ns/100ps
module readback_regs_bench;
  import rbr_pkg::*;
  logic             clk_in;
  logic             sys_rst_in;
  logic             sclk_in;
  logic             cs_n_in;
  logic             sdi_in;
  logic [6:0][31:0] regs_in;
  logic [11:0]      modulus_field_in;
  logic [11:0]      fraction_field_in;
  logic             sdo_out;
  logic             sdo_oe_out;
  logic [15:0]      modulus_out;
  logic [15:0]      fraction_out;
  logic             modulus_invalid_out;
  logic             resolution_16b_out;
  logic             serial_error_out;
  logic             frame_valid_out;
  logic [31:0]      frame_word_out;
  int               fail_count;
  int               n_checks;
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  readback_regs u_readback_regs (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .sclk_in(sclk_in),
    .cs_n_in(cs_n_in), .sdi_in(sdi_in), .regs_in(regs_in), .modulus_field_in(modulus_field_in),
    .fraction_field_in(fraction_field_in), .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out),
    .modulus_out(modulus_out), .fraction_out(fraction_out), .modulus_invalid_out(modulus_invalid_out),
    .resolution_16b_out(resolution_16b_out), .serial_error_out(serial_error_out),
    .frame_valid_out(frame_valid_out), .frame_word_out(frame_word_out));
  serial_host u_serial_host (.clk_in(clk_in), .sdo_in(sdo_out), .sdo_oe_in(sdo_oe_out),
    .sclk_out(sclk_in), .cs_n_out(cs_n_in), .sdi_out(sdi_in));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h want %h", $time, msg, got, exp);
    end
  endtask
  function automatic logic [31:0] w7(logic res, logic [3:0] mx, logic [3:0] fx, logic es, logic [2:0] p,
                                     logic rw);
    return {11'h0, res, 1'b1, 3'h0, mx, fx, es, p, rw, 3'h7};
  endfunction
  // Good frame, then bounded wait for the frame-end pulse
  task automatic send(input logic [31:0] w, input logic fall_smp);
    int i;
    u_serial_host.xfer(w, 32, fall_smp);
    for (i = 0; i < 40 && frame_valid_out !== 1'b1; i++) @(negedge clk_in);
    if (i == 40) begin
      fail_count++;
      $display("BAD %0t no frame pulse", $time);
      stop_test();
    end
    repeat (8) @(posedge clk_in);
    chk(frame_word_out, w, "frame word");
  endtask
  task automatic t_reset;
    chk({sdo_oe_out, serial_error_out, resolution_16b_out, modulus_invalid_out}, 32'h0, "reset flags");
    chk({sdo_out, frame_valid_out}, 32'h0, "reset link outputs");
    chk(frame_word_out, 32'h0, "reset frame word");
    chk(fraction_out, {4'h0, fraction_field_in}, "12-bit fraction");
    chk(modulus_out, {4'h0, modulus_field_in}, "12-bit modulus");
  endtask
  task automatic t_ext;
    send(w7(1'b1, 4'h1, 4'h5, 1'b1, 3'h0, 1'b0), 1'b0);
    chk({resolution_16b_out, modulus_invalid_out}, 32'h3, "modulus one invalid");
    chk(modulus_out, 32'h0001, "16-bit modulus low");
    chk(fraction_out, 32'h1235, "16-bit fraction");
    send(w7(1'b1, 4'h2, 4'hf, 1'b1, 3'h0, 1'b0), 1'b0);
    chk(modulus_invalid_out, 32'h0, "modulus two valid");
    @(posedge clk_in);
    modulus_field_in  <= 12'hfff;
    fraction_field_in <= 12'hfff;
    send(w7(1'b1, 4'hf, 4'hf, 1'b1, 3'h0, 1'b0), 1'b0);
    chk({modulus_out, fraction_out}, 32'hffff_ffff, "16-bit maxima");
  endtask
  task automatic t_code;
    send(w7(1'b0, 4'h0, 4'h0, 1'b1, 3'h0, 1'b0) & 32'hffff_fffe, 1'b0);
    chk(resolution_16b_out, 32'h1, "wrong code ignored");
  endtask
  task automatic t_count;
    u_serial_host.xfer(w7(1'b0, 4'h0, 4'h0, 1'b1, 3'h0, 1'b0), 31, 1'b0);
    repeat (16) @(posedge clk_in);
    chk({serial_error_out, resolution_16b_out}, 32'h3, "short frame");
    send(w7(1'b0, 4'h9, 4'h6, 1'b1, 3'h0, 1'b0), 1'b0);
    chk(serial_error_out, 32'h0, "error cleared");
    chk({modulus_out, fraction_out}, 32'h0fff_0fff, "extensions ignored");
  endtask
  task automatic t_read(input logic [2:0] p, input logic es);
    logic [31:0] exp;
    exp = (p == 3'h7) ? w7(1'b0, 4'h3, 4'h4, es, p, 1'b0) : regs_in[p];
    send(w7(1'b0, 4'h3, 4'h4, es, p, 1'b1), 1'b0);
    send(32'h0, !es);
    chk(u_serial_host.rd_word, exp, "readback word");
    chk(u_serial_host.oe_seen, 32'h1, "readback drive");
    send(32'h0, !es);
    chk(u_serial_host.oe_seen, 32'h0, "request cleared");
  endtask
  initial begin
    sys_rst_in        = 1'b1;
    modulus_field_in  = 12'h000;
    fraction_field_in = 12'h123;
    for (int i = 0; i < 7; i++) regs_in[i] = 32'ha5c3_0f00 ^ (32'h1111_1111 * (i + 1));
    fail_count = 0;
    n_checks   = 0;
    repeat (16) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    t_reset();
    t_ext();
    t_code();
    t_count();
    for (int p = 0; p < 8; p++) t_read(3'(p), p[0]);
    stop_test();
  end
endmodule

// File: bench/serial_host.sv
// Purpose: Serial host model that writes frames and collects readback data
// Assumes: Serial clock of 80 ns made from eight cycles of clk_in
// Notes:   Serial clock rests low between frames; data line flips when released
`timescale 1ns/100ps
module serial_host (
  input  wire logic clk_in,
  input  wire logic sdo_in,
  input  wire logic sdo_oe_in,
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      sdi_out
);
  logic [31:0] rd_word;
  logic        oe_seen;
  logic        sdo_line;
  // Undriven line shows the inverse so stale data cannot pass
  assign sdo_line = sdo_oe_in ? sdo_in : ~sdo_in;
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out  = 1'b0;
    rd_word  = 32'h0;
    oe_seen  = 1'b0;
  end
  // Sample edge follows the read-edge select the host has programmed
  task automatic xfer(input logic [31:0] w, input int n, input logic fall_smp);
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    oe_seen = 1'b0;
    repeat (8) @(posedge clk_in);
    for (int i = 0; i < n; i++) begin
      sdi_out <= w[5'(31 - i)];
      repeat (4) @(posedge clk_in);
      sclk_out <= 1'b1;
      oe_seen = oe_seen | sdo_oe_in;
      if (!fall_smp) rd_word = {rd_word[30:0], sdo_line};
      repeat (4) @(posedge clk_in);
      sclk_out <= 1'b0;
      if (fall_smp) rd_word = {rd_word[30:0], sdo_line};
    end
    repeat (4) @(posedge clk_in);
    cs_n_out <= 1'b1;
    sdi_out  <= ~sdi_out;
  endtask
endmodule

// File: rtl/frame_if.sv
// Purpose: Carries decoded serial-link events from the receiver to the core
// Assumes: All signals are on clk_in
// Notes:   Edges are one-cycle pulses
`timescale 1ns/100ps
interface frame_if;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_fall;
  logic        frame_done;
  logic        frame_ok;
  logic [31:0] word;
  modport rx (output sclk_rise, output sclk_fall, output cs_fall, output frame_done, output frame_ok, output word);
  modport core (input sclk_rise, input sclk_fall, input cs_fall, input frame_done, input frame_ok, input word);
endinterface

// File: rtl/rbr_pkg.sv
// Purpose: Shared constants for the readback and resolution register block
// Assumes: 32-bit serial frames, eight readable registers
// Notes:   Field positions are bit indices inside a received frame
package rbr_pkg;
  localparam int          FRAME_W    = 32;
  localparam int          NUM_REGS   = 8;
  localparam logic [5:0]  FRAME_BITS = 6'h20;
  localparam logic [5:0]  CNT_MAX    = 6'h3f;
  localparam logic [2:0]  CODE_REG7  = 3'h7;
  // Field positions of the readback control word
  localparam int          RES_BIT    = 20;
  localparam int          ONE_BIT    = 19;
  localparam int          MODX_HI    = 15;
  localparam int          MODX_LO    = 12;
  localparam int          FRACX_HI   = 11;
  localparam int          FRACX_LO   = 8;
  localparam int          EDGE_BIT   = 7;
  localparam int          PTR_HI     = 6;
  localparam int          PTR_LO     = 4;
  localparam int          RW_BIT     = 3;
  localparam int          CODE_HI    = 2;
  // Reset values and minimum valid modulus
  localparam logic        RES_RST    = 1'b0;
  localparam logic        EDGE_RST   = 1'b1;
  localparam logic [3:0]  EXT_RST    = 4'h0;
  localparam logic [2:0]  PTR_RST    = 3'h0;
  localparam logic [15:0] MOD_MIN    = 16'h0002;
endpackage

// File: rtl/readback_regs.sv
// Purpose: Readback control and resolution-extension register with serial readback
// Assumes: Registers 0 to 6 live outside and are presented on regs_in
// Notes:   Serial pins are asynchronous and pass two flip-flops first
//
// Function
// - 16-bit modulus is 12-bit field above 4-bit extension; 0 and 1 invalid.
// - 16-bit fraction is 12-bit field above 4-bit extension; extension resets zero.
// - Extensions take effect only when resolution select is one.
// - Read-edge bit: zero shifts data on rising, one on falling; resets one.
// - Three-bit pointer in bits six to four picks one of eight registers.
// - Selected register shifts out during the next 32-clock frame.
// - Read request bit clears itself and never reads back as one.
// - Word updates only when frame's low three bits equal 111.
// - Select one gives 16-bit values; zero gives 12-bit, extensions ignored.
// - Frames must hold exactly 32 clocks; other counts flag a serial error.
`timescale 1ns/100ps
module readback_regs
  import rbr_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             sclk_in,
  input  wire logic             cs_n_in,
  input  wire logic             sdi_in,
  input  wire logic [6:0][31:0] regs_in,
  input  wire logic [11:0]      modulus_field_in,
  input  wire logic [11:0]      fraction_field_in,
  output logic                  sdo_out,
  output logic                  sdo_oe_out,
  output logic [15:0]           modulus_out,
  output logic [15:0]           fraction_out,
  output logic                  modulus_invalid_out,
  output logic                  resolution_16b_out,
  output logic                  serial_error_out,
  output logic                  frame_valid_out,
  output logic [31:0]           frame_word_out
);
  typedef struct packed {
    logic        res;
    logic [3:0]  modx;
    logic [3:0]  fracx;
    logic        edge_sel;
    logic [2:0]  ptr;
    logic        rd_pend;
    logic        rd_act;
    logic [31:0] sh;
    logic        sdo;
    logic        err;
    logic        wr_stb;
    logic [31:0] word;
    logic [5:0]  ecnt;
    logic [15:0] mod_o;
    logic [15:0] fraction_field_o;
    logic        mod_bad;
  } core_s;

  localparam core_s CORE_RST = '{res: RES_RST, modx: EXT_RST, fracx: EXT_RST, edge_sel: EDGE_RST,
                                 ptr: PTR_RST, rd_pend: 1'b0, rd_act: 1'b0, sh: 32'h0, sdo: 1'b0,
                                 err: 1'b0, wr_stb: 1'b0, word: 32'h0, ecnt: 6'h00, mod_o: 16'h0000,
                                 fraction_field_o: 16'h0000, mod_bad: 1'b0};

  frame_if fr ();

  serial_frame_rx u_rx (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .sclk_in    (sclk_in),
    .cs_n_in    (cs_n_in),
    .sdi_in     (sdi_in),
    .fr         (fr.rx)
  );

  core_s                      q;
  core_s                      d;
  logic [31:0]                reg7_img;
  logic [NUM_REGS-1:0][31:0]  all_regs;
  logic [31:0]                sel_word;
  logic                       shift_now;
  logic                       reg7_hit;

  // Read bit always shows zero; fixed-one bit shows one
  always_comb begin
    reg7_img                   = 32'h0;
    reg7_img[RES_BIT]          = q.res;
    reg7_img[ONE_BIT]          = 1'b1;
    reg7_img[MODX_HI:MODX_LO]  = q.modx;
    reg7_img[FRACX_HI:FRACX_LO] = q.fracx;
    reg7_img[EDGE_BIT]         = q.edge_sel;
    reg7_img[PTR_HI:PTR_LO]    = q.ptr;
    reg7_img[CODE_HI:0]        = CODE_REG7;
  end

  assign all_regs = {reg7_img, regs_in};
  assign sel_word = all_regs[q.ptr];
  assign reg7_hit = fr.frame_done && fr.frame_ok && (fr.word[CODE_HI:0] == CODE_REG7);

  assign shift_now = q.rd_act && (q.edge_sel ? fr.sclk_fall : (fr.sclk_rise && q.ecnt != 6'h00));

  always_comb begin
    d        = q;
    d.wr_stb = 1'b0;
    if (fr.frame_done) begin
      d.err    = ~fr.frame_ok;
      d.rd_act = 1'b0;
      d.sdo    = 1'b0;
      d.wr_stb = fr.frame_ok;
      d.word   = fr.word;
      if (reg7_hit) begin
        d.res      = fr.word[RES_BIT];
        d.modx     = fr.word[MODX_HI:MODX_LO];
        d.fracx    = fr.word[FRACX_HI:FRACX_LO];
        d.edge_sel = fr.word[EDGE_BIT];
        d.ptr      = fr.word[PTR_HI:PTR_LO];
        d.rd_pend  = fr.word[RW_BIT];
      end
    end else if (fr.cs_fall && q.rd_pend) begin
      d.rd_pend = 1'b0;
      d.rd_act  = 1'b1;
      d.sh      = sel_word;
      d.sdo     = sel_word[FRAME_W-1];
    end else if (shift_now) begin
      d.sh  = {q.sh[30:0], 1'b0};
      d.sdo = q.sh[FRAME_W-2];
    end
    // Counts rising edges so the rising mode skips the edge that would drop the MSB
    if (fr.cs_fall) begin
      d.ecnt = 6'h00;
    end else if (fr.sclk_rise && q.ecnt != CNT_MAX) begin
      d.ecnt = q.ecnt + 6'h01;
    end
    // Twelve-bit mode ignores the extensions entirely; outputs lag one cycle
    if (q.res) begin
      d.mod_o  = {modulus_field_in, q.modx};
      d.fraction_field_o = {fraction_field_in, q.fracx};
    end else begin
      d.mod_o  = {4'h0, modulus_field_in};
      d.fraction_field_o = {4'h0, fraction_field_in};
    end
    d.mod_bad = q.res && (d.mod_o < MOD_MIN);
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      q <= CORE_RST;
    end else begin
      q <= d;
    end
  end

  assign modulus_out         = q.mod_o;
  assign fraction_out        = q.fraction_field_o;
  assign modulus_invalid_out = q.mod_bad;
  assign resolution_16b_out  = q.res;
  assign sdo_out             = q.sdo;
  assign sdo_oe_out          = q.rd_act;
  assign serial_error_out    = q.err;
  assign frame_valid_out     = q.wr_stb;
  assign frame_word_out      = q.word;

  property p_mod16;
    @(posedge clk_in) disable iff (sys_rst_in)
      q.res |=> modulus_out == {$past(modulus_field_in), $past(q.modx)}
                && modulus_invalid_out == ({$past(modulus_field_in), $past(q.modx)} < MOD_MIN);
  endproperty
  a_mod16: assert property (p_mod16) else $error("16-bit modulus wrong");

  property p_ext_apply;
    @(posedge clk_in) disable iff (sys_rst_in)
      reg7_hit |=> q.fracx == $past(fr.word[FRACX_HI:FRACX_LO]) && q.res == $past(fr.word[RES_BIT]);
  endproperty
  a_ext_apply: assert property (p_ext_apply) else $error("fraction extension not taken");

  property p_mod12;
    @(posedge clk_in) disable iff (sys_rst_in)
      !q.res |=> modulus_out == {4'h0, $past(modulus_field_in)} && fraction_out == {4'h0, $past(fraction_field_in)}
                 && !modulus_invalid_out;
  endproperty
  a_mod12: assert property (p_mod12) else $error("12-bit mode uses extensions");

  property p_edge_shift;
    @(posedge clk_in) disable iff (sys_rst_in)
      q.rd_act && q.edge_sel && fr.sclk_fall && !fr.frame_done |=> sdo_out == $past(q.sh[30]);
  endproperty
  a_edge_shift: assert property (p_edge_shift) else $error("falling-edge shift missing");

  property p_first_rise;
    @(posedge clk_in) disable iff (sys_rst_in)
      q.rd_act && !q.edge_sel && fr.sclk_rise && q.ecnt == 6'h00 |=> sdo_out == $past(q.sh[31]);
  endproperty
  a_first_rise: assert property (p_first_rise) else $error("rising mode dropped the first bit");

  property p_load;
    @(posedge clk_in) disable iff (sys_rst_in)
      fr.cs_fall && q.rd_pend |=> q.sh == $past(sel_word) && sdo_out == $past(sel_word[31]) && sdo_oe_out;
  endproperty
  a_load: assert property (p_load) else $error("readback load wrong");

  property p_selfclear;
    @(posedge clk_in) disable iff (sys_rst_in)
      q.rd_pend && fr.cs_fall |=> !q.rd_pend ##1 !q.rd_pend || fr.frame_done;
  endproperty
  a_selfclear: assert property (p_selfclear) else $error("read request did not clear");

  property p_code;
    @(posedge clk_in) disable iff (sys_rst_in)
      !reg7_hit |=> $stable(q.ptr) && $stable(q.modx) && $stable(q.edge_sel);
  endproperty
  a_code: assert property (p_code) else $error("word changed without code 111");

  property p_err;
    @(posedge clk_in) disable iff (sys_rst_in)
      fr.frame_done |=> serial_error_out == !$past(fr.frame_ok) && frame_valid_out == $past(fr.frame_ok);
  endproperty
  a_err: assert property (p_err) else $error("frame error flag wrong");

  property p_bad_frame;
    @(posedge clk_in) disable iff (sys_rst_in)
      fr.frame_done && !fr.frame_ok |=> $stable(q.res) && $stable(q.fracx) && $stable(q.ptr) && !frame_valid_out;
  endproperty
  a_bad_frame: assert property (p_bad_frame) else $error("bad frame changed fields");

  property p_end;
    @(posedge clk_in) disable iff (sys_rst_in)
      fr.frame_done |=> !sdo_oe_out;
  endproperty
  a_end: assert property (p_end) else $error("readback outlived its frame");
endmodule

// File: rtl/serial_frame_rx.sv
// Purpose: Synchronises the serial pins and assembles 32-bit frames
// Assumes: Serial clock far slower than clk_in
// Notes:   Data is sampled on the rising serial-clock edge, MSB first
`timescale 1ns/100ps
module serial_frame_rx
  import rbr_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  input  wire logic sclk_in,
  input  wire logic cs_n_in,
  input  wire logic sdi_in,
  frame_if.rx       fr
);
  typedef struct packed {
    logic [2:0]  sclk_s;
    logic [2:0]  cs_s;
    logic [1:0]  sdi_s;
    logic [5:0]  cnt;
    logic [31:0] sh;
    logic        done;
    logic        ok;
    logic [31:0] word;
  } rx_s;

  localparam rx_s RX_RST = '{sclk_s: 3'h0, cs_s: 3'h7, sdi_s: 2'h0, cnt: 6'h00,
                             sh: 32'h0, done: 1'b0, ok: 1'b0, word: 32'h0};

  rx_s  q;
  rx_s  d;
  logic rise;
  logic fall;
  logic cs_fall;
  logic cs_rise;

  // Stage 0 feeds only stage 1; edges compare stages 1 and 2
  assign rise    = q.sclk_s[1] & ~q.sclk_s[2];
  assign fall    = ~q.sclk_s[1] & q.sclk_s[2];
  assign cs_fall = ~q.cs_s[1] & q.cs_s[2];
  assign cs_rise = q.cs_s[1] & ~q.cs_s[2];

  always_comb begin
    d        = q;
    d.sclk_s = {q.sclk_s[1:0], sclk_in};
    d.cs_s   = {q.cs_s[1:0], cs_n_in};
    d.sdi_s  = {q.sdi_s[0], sdi_in};
    d.done   = 1'b0;
    if (cs_fall) begin
      d.cnt = 6'h00;
    end else if (rise && !q.cs_s[1]) begin
      d.sh = {q.sh[30:0], q.sdi_s[1]};
      if (q.cnt != CNT_MAX) begin
        d.cnt = q.cnt + 6'h01;
      end
    end
    if (cs_rise) begin
      d.done = 1'b1;
      d.ok   = (q.cnt == FRAME_BITS);
      d.word = q.sh;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      q <= RX_RST;
    end else begin
      q <= d;
    end
  end

  assign fr.sclk_rise  = rise;
  assign fr.sclk_fall  = fall;
  assign fr.cs_fall    = cs_fall;
  assign fr.frame_done = q.done;
  assign fr.frame_ok   = q.ok;
  assign fr.word       = q.word;

  property p_count_ok;
    @(posedge clk_in) disable iff (sys_rst_in)
      cs_rise |=> (q.ok == ($past(q.cnt) == FRAME_BITS)) && q.done;
  endproperty
  a_count_ok: assert property (p_count_ok) else $error("frame length check wrong");
endmodule
